// >>> src/vctg_clamp_timing.sv
`timescale 1ns/1ps
`default_nettype none
module vctg_clamp_timing #(
    parameter logic [6:0] DEV_ADDR = vctg_pkg::VCTG_DEV_ADDR_DEFAULT
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic line_sync_input_a,
    input wire logic line_sync_input_b,
    input wire logic line_sync_select,
    input wire logic clamp_strobe,
    input wire logic [9:0] adc_red,
    input wire logic [9:0] adc_green,
    input wire logic [9:0] adc_blue,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic clamp_window,
    output logic [9:0] data_red,
    output logic [9:0] data_green,
    output logic [9:0] data_blue
);
    import vctg_pkg::*;

    typedef struct packed {
        vctg_state_t st;
        logic [7:0] cnt;
        logic [7:0] ctl;
        logic [7:0] dly;
        logic [7:0] len;
        logic sync_prev;
        logic window;
        logic [2:0][10:0] offset;
        logic [2:0][9:0] data;
        logic [8:0] since;
        logic [8:0] on_cnt;
        logic [1:0] per_line;
    } vctg_core_t;

    vctg_core_t core_reg;
    vctg_core_t core_next;
    logic sync_now;
    logic trail;
    logic internal;
    logic ext_level;
    logic [7:0] reg_addr;
    logic [7:0] reg_rdata;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [2:0][9:0] raw;
    logic [2:0][11:0] sum;
    logic [2:0][9:0] sat;
    logic [2:0][9:0] target;

    ////////////////////////////////////////////////////////////////////////
    vctg_serial_port #(.DEV_ADDR(DEV_ADDR)) u_port (
        .clock(clock),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .reg_addr(reg_addr),
        .reg_rdata(reg_rdata),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    always_comb begin
        unique case (reg_addr)
            VCTG_ADDR_CONTROL: reg_rdata = core_reg.ctl;
            VCTG_ADDR_DELAY: reg_rdata = core_reg.dly;
            VCTG_ADDR_LENGTH: reg_rdata = core_reg.len;
            default: reg_rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        core_next = core_reg;
        raw = {adc_red, adc_green, adc_blue};
        sync_now = line_sync_select ? line_sync_input_b : line_sync_input_a;
        core_next.sync_prev = sync_now;
        // Falling edge ends an active-high sync; back porch follows it
        trail = core_reg.sync_prev & ~sync_now;
        internal = ~core_reg.ctl[VCTG_SRC_BIT];
        ext_level = core_reg.ctl[VCTG_POL_OVR_BIT] ? core_reg.ctl[VCTG_POL_LEVEL_BIT] : 1'b1;

        if (wr_en) begin
            // Whole bytes: 0 to 255 pixel periods of delay and length
            if (wr_addr == VCTG_ADDR_CONTROL) core_next.ctl = wr_data;
            if (wr_addr == VCTG_ADDR_DELAY) core_next.dly = wr_data;
            if (wr_addr == VCTG_ADDR_LENGTH) core_next.len = wr_data;
        end

        // Any trailing edge restarts the sequence, even inside a window
        if (trail) begin
            if (core_reg.dly != 8'h00) begin
                core_next.st = VCTG_DELAY;
                core_next.cnt = core_reg.dly;
            end else if (core_reg.len != 8'h00) begin
                core_next.st = VCTG_CLAMP;
                core_next.cnt = core_reg.len;
            end else begin
                core_next.st = VCTG_IDLE;
            end
        end else begin
            unique case (core_reg.st)
                VCTG_IDLE: begin
                end
                VCTG_DELAY: begin
                    if (core_reg.cnt == 8'h01) begin
                        core_next.st = (core_reg.len != 8'h00) ? VCTG_CLAMP : VCTG_IDLE;
                        core_next.cnt = core_reg.len;
                    end else begin
                        core_next.cnt = core_reg.cnt - 8'h01;
                    end
                end
                VCTG_CLAMP: begin
                    if (core_reg.cnt == 8'h01) begin
                        core_next.st = VCTG_IDLE;
                    end else begin
                        core_next.cnt = core_reg.cnt - 8'h01;
                    end
                end
                default: core_next.st = VCTG_IDLE;
            endcase
        end

        if (internal) begin
            core_next.window = (core_next.st == VCTG_CLAMP);
        end else begin
            core_next.window = (clamp_strobe == ext_level);
        end

        // Offset only moves inside the window and is held for the rest of the line
        for (int i = 0; i < VCTG_CHANNELS; i++) begin
            sum[i] = {2'b00, raw[i]} + {core_reg.offset[i][10], core_reg.offset[i]};
            if (sum[i][11]) begin
                sat[i] = VCTG_GROUND_CODE;
            end else if (sum[i][10]) begin
                sat[i] = VCTG_CODE_MAX;
            end else begin
                sat[i] = sum[i][9:0];
            end
            target[i] = core_reg.ctl[VCTG_SEL_LSB + i] ? VCTG_MIDSCALE_CODE
                                                       : VCTG_GROUND_CODE;
            core_next.data[i] = sat[i];
            if (core_reg.window) begin
                if (sat[i] > target[i] && core_reg.offset[i] != VCTG_OFS_MIN) begin
                    core_next.offset[i] = core_reg.offset[i] - 11'h001;
                end else if (sat[i] < target[i] && core_reg.offset[i] != VCTG_OFS_MAX) begin
                    core_next.offset[i] = core_reg.offset[i] + 11'h001;
                end
            end
        end

        // Observation counters for the checks below
        core_next.since = trail ? 9'h000 :
            (core_reg.since == VCTG_HELPER_MAX) ? core_reg.since : core_reg.since + 9'h001;
        core_next.on_cnt = !core_reg.window ? 9'h000 :
            (core_reg.on_cnt == VCTG_HELPER_MAX) ? core_reg.on_cnt : core_reg.on_cnt + 9'h001;
        if (trail) begin
            core_next.per_line = {1'b0, core_next.window & ~core_reg.window};
        end else if (core_next.window && !core_reg.window && core_reg.per_line != 2'h3) begin
            core_next.per_line = core_reg.per_line + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            core_reg <= '{st: VCTG_IDLE, ctl: VCTG_CONTROL_RESET, dly: VCTG_DELAY_RESET,
                          len: VCTG_LENGTH_RESET, default: '0};
        end else begin
            core_reg <= core_next;
        end
    end

    assign clamp_window = core_reg.window;
    assign data_red = core_reg.data[2];
    assign data_green = core_reg.data[1];
    assign data_blue = core_reg.data[0];

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_trail_int;
        trail && internal;
    endsequence

    sequence s_blue_low_mid;
        clamp_window && core_reg.ctl[VCTG_SEL_LSB] && sat[0] < VCTG_MIDSCALE_CODE
            && core_reg.offset[0] != VCTG_OFS_MAX;
    endsequence

    a_zero_delay_start: assert property (s_trail_int ##0 (core_reg.dly == 8'h00
        && core_reg.len != 8'h00) |=> clamp_window) else $error("no window after zero delay");
    a_delay_wait: assert property ($rose(clamp_window) && internal
        |-> core_reg.since == {1'b0, core_reg.dly}) else $error("window start misplaced");
    a_window_length: assert property ($fell(clamp_window) && internal && !$past(trail)
        |-> core_reg.on_cnt == {1'b0, core_reg.len}) else $error("window length wrong");
    a_trailing_ref: assert property (s_trail_int ##0 core_reg.dly != 8'h00
        |=> !clamp_window) else $error("window not restarted at trailing edge");
    a_one_per_line: assert property (internal |-> core_reg.per_line <= 2'h1)
        else $error("more than one window in a line");
    a_ext_source: assert property (!internal && !core_reg.ctl[VCTG_POL_OVR_BIT]
        |=> clamp_window == $past(clamp_strobe)) else $error("strobe not followed");
    a_ext_polarity: assert property (!internal && core_reg.ctl[VCTG_POL_OVR_BIT]
        |=> clamp_window == ($past(clamp_strobe) == $past(core_reg.ctl[VCTG_POL_LEVEL_BIT])))
        else $error("strobe polarity wrong");
    a_offset_hold: assert property (!clamp_window |=> $stable(core_reg.offset))
        else $error("offset moved outside window");
    a_offset_down: assert property (clamp_window && sat[1] > target[1]
        && core_reg.offset[1] != VCTG_OFS_MIN
        |=> core_reg.offset[1] == $past(core_reg.offset[1]) - 11'h001)
        else $error("offset did not step toward black");
    a_mid_target: assert property (s_blue_low_mid
        |=> core_reg.offset[0] == $past(core_reg.offset[0]) + 11'h001)
        else $error("midscale target ignored");
endmodule
`default_nettype wire

// >>> src/vctg_pkg.sv
package vctg_pkg;
    localparam logic [7:0] VCTG_ADDR_CONTROL = 8'h18;
    localparam logic [7:0] VCTG_ADDR_DELAY = 8'h19;
    localparam logic [7:0] VCTG_ADDR_LENGTH = 8'h1A;
    localparam logic [7:0] VCTG_CONTROL_RESET = 8'h00;
    localparam logic [7:0] VCTG_DELAY_RESET = 8'h04;
    localparam logic [7:0] VCTG_LENGTH_RESET = 8'h28;
    localparam int VCTG_POL_OVR_BIT = 7;
    localparam int VCTG_POL_LEVEL_BIT = 6;
    localparam int VCTG_SRC_BIT = 4;
    localparam int VCTG_SEL_LSB = 1;
    localparam int VCTG_CHANNELS = 3;
    localparam logic [9:0] VCTG_GROUND_CODE = 10'h000;
    localparam logic [9:0] VCTG_MIDSCALE_CODE = 10'h200;
    localparam logic [9:0] VCTG_CODE_MAX = 10'h3FF;
    localparam logic [10:0] VCTG_OFS_MAX = 11'h3FF;
    localparam logic [10:0] VCTG_OFS_MIN = 11'h400;
    localparam logic [8:0] VCTG_HELPER_MAX = 9'h1FF;
    // Arbitrary neutral serial port address
    localparam logic [6:0] VCTG_DEV_ADDR_DEFAULT = 7'h4C;
    typedef enum logic [2:0] {
        VCTG_IDLE = 3'b001,
        VCTG_DELAY = 3'b010,
        VCTG_CLAMP = 3'b100
    } vctg_state_t;
    typedef enum logic [4:0] {
        VCTG_SP_IDLE = 5'b00001,
        VCTG_SP_RECV = 5'b00010,
        VCTG_SP_ACK = 5'b00100,
        VCTG_SP_SEND = 5'b01000,
        VCTG_SP_MACK = 5'b10000
    } vctg_sp_state_t;
endpackage

// >>> src/vctg_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module vctg_serial_port #(
    parameter logic [6:0] DEV_ADDR = vctg_pkg::VCTG_DEV_ADDR_DEFAULT
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data
);
    import vctg_pkg::*;

    typedef struct packed {
        vctg_sp_state_t st;
        logic scl_prev;
        logic sda_prev;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic [1:0] byte_idx;
        logic rw;
        logic [7:0] ptr;
        logic sda_oe;
        logic wr_en;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } vctg_sp_t;

    vctg_sp_t sp_reg;
    vctg_sp_t sp_next;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        sp_next = sp_reg;
        sp_next.wr_en = 1'b0;
        sp_next.scl_prev = scl_in;
        sp_next.sda_prev = sda_in;
        rise = scl_in & ~sp_reg.scl_prev;
        fall = ~scl_in & sp_reg.scl_prev;
        start = scl_in & sp_reg.scl_prev & sp_reg.sda_prev & ~sda_in;
        stop = scl_in & sp_reg.scl_prev & ~sp_reg.sda_prev & sda_in;
        if (start) begin
            sp_next.st = VCTG_SP_RECV;
            sp_next.bitcnt = 4'h0;
            sp_next.byte_idx = 2'h0;
            sp_next.sda_oe = 1'b0;
        end else if (stop) begin
            sp_next.st = VCTG_SP_IDLE;
            sp_next.sda_oe = 1'b0;
        end else begin
            unique case (sp_reg.st)
                VCTG_SP_IDLE: begin
                end
                VCTG_SP_RECV: begin
                    if (rise) begin
                        sp_next.shift = {sp_reg.shift[6:0], sda_in};
                        sp_next.bitcnt = sp_reg.bitcnt + 4'h1;
                    end else if (fall && sp_reg.bitcnt == 4'h8) begin
                        sp_next.bitcnt = 4'h0;
                        sp_next.st = VCTG_SP_ACK;
                        sp_next.sda_oe = 1'b1;
                        if (sp_reg.byte_idx == 2'h0) begin
                            sp_next.rw = sp_reg.shift[0];
                            sp_next.byte_idx = 2'h1;
                            // Foreign address: stay off the bus until the next start
                            if (sp_reg.shift[7:1] != DEV_ADDR) begin
                                sp_next.st = VCTG_SP_IDLE;
                                sp_next.sda_oe = 1'b0;
                            end
                        end else if (sp_reg.byte_idx == 2'h1) begin
                            sp_next.ptr = sp_reg.shift;
                            sp_next.byte_idx = 2'h2;
                        end else begin
                            sp_next.wr_en = 1'b1;
                            sp_next.wr_addr = sp_reg.ptr;
                            sp_next.wr_data = sp_reg.shift;
                            sp_next.ptr = sp_reg.ptr + 8'h01;
                        end
                    end
                end
                VCTG_SP_ACK: begin
                    if (fall) begin
                        if (sp_reg.rw) begin
                            sp_next.shift = reg_rdata;
                            sp_next.sda_oe = ~reg_rdata[7];
                            sp_next.st = VCTG_SP_SEND;
                            sp_next.bitcnt = 4'h0;
                        end else begin
                            sp_next.sda_oe = 1'b0;
                            sp_next.st = VCTG_SP_RECV;
                        end
                    end
                end
                VCTG_SP_SEND: begin
                    if (fall) begin
                        if (sp_reg.bitcnt == 4'h7) begin
                            sp_next.sda_oe = 1'b0;
                            sp_next.st = VCTG_SP_MACK;
                            sp_next.ptr = sp_reg.ptr + 8'h01;
                        end else begin
                            sp_next.shift = {sp_reg.shift[6:0], 1'b0};
                            sp_next.sda_oe = ~sp_reg.shift[6];
                            sp_next.bitcnt = sp_reg.bitcnt + 4'h1;
                        end
                    end
                end
                VCTG_SP_MACK: begin
                    if (rise) begin
                        sp_next.st = sda_in ? VCTG_SP_IDLE : VCTG_SP_ACK;
                    end
                end
                default: sp_next.st = VCTG_SP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            sp_reg <= '{st: VCTG_SP_IDLE, scl_prev: 1'b1, sda_prev: 1'b1, default: '0};
        end else begin
            sp_reg <= sp_next;
        end
    end

    // Open drain: the pad only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = sp_reg.sda_oe;
    assign reg_addr = sp_reg.ptr;
    assign wr_en = sp_reg.wr_en;
    assign wr_addr = sp_reg.wr_addr;
    assign wr_data = sp_reg.wr_data;
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import vctg_pkg::*;
    typedef struct {int d; int l;} vctg_note_t;
    logic clock, reset, go, sel, scl_m, sda_m, lvl, probe, rd_stb, ext, watch;
    logic sda_oe, sda_out, win, psync, pstrobe, sync_q, strb_q, win_q, armed, sda_w;
    logic noise = 1'b0;
    logic [7:0] sw, sd, sl, rd_val;
    logic [9:0] black, video, pcode, dr, dg, db;
    logic [31:0] r;
    int seed = 68;
    int bad_count, check_count, cyc, t0, hi;
    vctg_note_t notes[$];
    vctg_note_t cur;
    logic [7:0] exp_rd[$];
    logic [29:0] exp_dat[$];
    localparam logic [7:0] WR = {VCTG_DEV_ADDR_DEFAULT, 1'b0};

    // Open drain wire: released level is the pull-up
    assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);

    vctg_video_source src (.clock(clock), .reset(reset), .go(go), .sync_width(sw),
        .strobe_delay(sd), .strobe_len(sl), .strobe_level(lvl), .black_level(black),
        .video_level(video), .line_sync(psync), .clamp_strobe(pstrobe), .video_code(pcode));

    vctg_clamp_timing dut (.clock(clock), .reset(reset),
        .line_sync_input_a(sel ? noise : psync), .line_sync_input_b(sel ? psync : noise),
        .line_sync_select(sel), .clamp_strobe(pstrobe), .adc_red(pcode), .adc_green(pcode),
        .adc_blue(pcode), .scl_in(scl_m), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .clamp_window(win), .data_red(dr), .data_green(dg), .data_blue(db));

    always #20 clock = ~clock;
    // The unused sync input toggles so that a wrong select shows up
    always @(posedge clock) noise <= ~noise;

    task automatic tk(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic tally(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        tally(got === exp, "register byte mismatch");
    endtask
    task automatic check_time(input int got, input int exp);
        tally(got == exp, "window timing mismatch");
    endtask
    task automatic check_code(input logic [29:0] got, input logic [29:0] exp);
        tally(got === exp, "corrected code mismatch");
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [29:0] codes(input logic [7:0] ctl, input logic [9:0] raw);
        logic [29:0] rv;
        int v;
        for (int c = 0; c < 3; c++) begin
            v = int'(raw) - int'(black);
            v = v + (ctl[c + 1] ? int'(VCTG_MIDSCALE_CODE) : int'(VCTG_GROUND_CODE));
            rv[c * 10 +: 10] = (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : v[9:0];
        end
        return rv;
    endfunction
    // Serial phases of at least three clocks each
    task automatic sbit(input logic b);
        sda_m <= b;
        tk(4);
        scl_m <= 1'b1;
        tk(4);
        scl_m <= 1'b0;
        tk(3);
    endtask
    task automatic rbit(output logic b);
        sda_m <= 1'b1;
        tk(4);
        scl_m <= 1'b1;
        tk(2);
        b = sda_w;
        tk(2);
        scl_m <= 1'b0;
        tk(3);
    endtask
    task automatic sstart;
        sda_m <= 1'b1;
        tk(3);
        scl_m <= 1'b1;
        tk(4);
        sda_m <= 1'b0;
        tk(4);
        scl_m <= 1'b0;
        tk(3);
    endtask
    task automatic sstop;
        sda_m <= 1'b0;
        tk(3);
        scl_m <= 1'b1;
        tk(4);
        sda_m <= 1'b1;
        tk(4);
    endtask
    task automatic wbyte(input logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) sbit(v[i]);
        rbit(a);
        check_byte({7'h00, a}, 8'h00);
    endtask
    task automatic rbyte(input logic [7:0] e, input logic last);
        logic [7:0] v;
        exp_rd.push_back(e);
        for (int i = 7; i >= 0; i--) rbit(v[i]);
        rd_val <= v;
        rd_stb <= 1'b1;
        tk(1);
        rd_stb <= 1'b0;
        sbit(last);
    endtask
    task automatic read4(input logic [31:0] e);
        sstart;
        wbyte(WR);
        wbyte(VCTG_ADDR_CONTROL);
        sstart;
        wbyte(WR | 8'h01);
        for (int i = 3; i >= 0; i--) rbyte(e[i * 8 +: 8], i == 0);
        sstop;
    endtask
    // Monitoring pauses while the mode changes, since the window may glitch then
    task automatic cfg(input logic [7:0] c, input logic [7:0] d, input logic [7:0] l);
        watch <= 1'b0;
        sstart;
        wbyte(WR);
        wbyte(VCTG_ADDR_CONTROL);
        wbyte(c);
        wbyte(d);
        wbyte(l);
        sstop;
        tk(4);
        watch <= 1'b1;
    endtask
    task automatic pr(input logic [29:0] e);
        exp_dat.push_back(e);
        probe <= 1'b1;
        tk(1);
        probe <= 1'b0;
    endtask
    task automatic line(input int d, input int l, input logic [7:0] ctl, input logic chk);
        notes.push_back('{d, l});
        go <= 1'b1;
        tk(1);
        go <= 1'b0;
        tk(548);
        if (chk) begin
            pr(codes(ctl, black));
            tk(30);
            pr(codes(ctl, video));
        end
        tk(60);
    endtask

    always @(posedge clock) begin
        cyc++;
        if (watch && (ext ? (pstrobe === lvl && strb_q !== lvl) : (psync === 1'b0 && sync_q === 1'b1))) begin
            if (notes.size() > 0) begin
                cur = notes.pop_front();
                t0 = cyc;
                hi = 0;
                armed = 1'b1;
            end
        end
        if (win === 1'b1) begin
            if (win_q !== 1'b1 && watch) begin
                // Edge seen in the same sample as the core, window registered once: delay plus one
                if (armed) check_time(cyc - t0, cur.d + 1);
                else tally(1'b0, "window without a cause");
            end
            hi++;
        end else if (win_q === 1'b1 && armed) begin
            check_time(hi, cur.l);
            armed = 1'b0;
        end
        win_q = win;
        sync_q = psync;
        strb_q = pstrobe;
        if (rd_stb) check_byte(rd_val, exp_rd.pop_front());
        if (probe) check_code({dr, dg, db}, exp_dat.pop_front());
    end

    initial begin
        tk(60000);
        bad_count++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        go = 1'b0;
        sel = 1'b0;
        scl_m = 1'b1;
        sda_m = 1'b1;
        lvl = 1'b1;
        probe = 1'b0;
        rd_stb = 1'b0;
        ext = 1'b0;
        watch = 1'b1;
        armed = 1'b0;
        sw = 8'h14;
        sd = 8'h00;
        sl = 8'h00;
        black = 10'h01E;
        video = 10'h2A5;
        rd_val = 8'h00;
        tk(2);
        reset <= 1'b0;
        tk(2);
        // Unmapped write must be dropped
        sstart;
        wbyte(WR);
        wbyte(8'h1B);
        wbyte(8'h5A);
        sstop;
        read4({VCTG_CONTROL_RESET, VCTG_DELAY_RESET, VCTG_LENGTH_RESET, 8'h00});
        cfg(8'h00, 8'h04, 8'h28);
        line(4, 40, 8'h00, 1'b1);
        cfg(8'h0E, 8'h00, 8'hFF);
        for (int k = 0; k < 3; k++) line(0, 255, 8'h0E, k == 2);
        cfg(8'h0A, 8'hFF, 8'hFF);
        for (int k = 0; k < 3; k++) line(255, 255, 8'h0A, k == 2);
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            sel <= r[24];
            sw <= 8'h08 + {4'h0, r[3:0]};
            video <= r[31:22];
            cfg(8'h0A, r[15:8], {r[23:17], 1'b1});
            line(int'(r[15:8]), int'({r[23:17], 1'b1}), 8'h0A, 1'b1);
        end
        for (int k = 0; k < 3; k++) begin
            r = $random(seed);
            lvl <= (k != 2);
            ext <= 1'b1;
            sd <= {2'b00, r[5:0]};
            sl <= {2'b00, r[13:8]} + 8'h01;
            cfg(k == 0 ? 8'h1A : k == 1 ? 8'hDA : 8'h9A, 8'h10, 8'h05);
            line(0, int'(r[13:8]) + 1, 8'h0A, 1'b1);
        end
        read4({8'h9A, 8'h10, 8'h05, 8'h00});
        stop_test();
    end
endmodule
`default_nettype wire

// >>> testbench/vctg_video_source.sv
`timescale 1ns/1ps
`default_nettype none
module vctg_video_source #(
    parameter int LINE_LEN = 600,
    parameter int ACT_START = 560
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic go,
    input wire logic [7:0] sync_width,
    input wire logic [7:0] strobe_delay,
    input wire logic [7:0] strobe_len,
    input wire logic strobe_level,
    input wire logic [9:0] black_level,
    input wire logic [9:0] video_level,
    output logic line_sync,
    output logic clamp_strobe,
    output logic [9:0] video_code
);
    int cnt;
    int s0;
    // One line per go; idle holds black with sync low
    always_ff @(posedge clock) begin
        if (reset) begin
            cnt <= LINE_LEN;
        end else if (go) begin
            cnt <= 0;
        end else if (cnt < LINE_LEN) begin
            cnt <= cnt + 1;
        end
    end
    // Sync first, then a black back porch, video only from ACT_START
    assign line_sync = cnt < int'(sync_width);
    assign s0 = int'(sync_width) + int'(strobe_delay);
    // Strobe sits in the porch; callers keep it 16 clocks clear of video
    assign clamp_strobe = (cnt >= s0 && cnt < s0 + int'(strobe_len)) ? strobe_level : ~strobe_level;
    assign video_code = (cnt >= ACT_START && cnt < LINE_LEN) ? video_level : black_level;
endmodule
`default_nettype wire
